// [i2c_slave_port.sv]
// Functional notes
// - bus select low enables two-wire port, high enables four-wire port
// - slave only; standard, fast and high-speed rates, same protocol
// - only 7-bit addresses; no 10-bit or general-call response
// - slave address from three straps via fixed eight-entry table
// - start is data falling while clock high; device detects it
// - acknowledge only on address match, data low through ninth clock
// - every byte followed by acknowledge from receiver, repeats freely; low byte nacked while the two-word write buffer is full, unless pointer is 6bh or 7ch
// - stop is data rising while clock high; release, await start
// - soft reset: any value on two-wire, only 6600h on four-wire
// - communication blocked during soft reset; host waits 30 us
// - reset pin low holds all registers at defaults
// - in reset all blocks but temperature sensor powered down
// - ready within 250 us after reset release or power-up
// - power-on reset acts as the reset pin does
// - high-speed master code recognised, never acknowledged, stop ends it
// - words go high byte first; write on low, read frozen
// - pointer changes only by a write pointer byte or a reset (pin, power-on or soft), which clears it to 00h
// - line held low 32.8 ms in frame resets serial port
`timescale 1ns/1ps
`include "i2c_port_defs.svh"

module i2c_slave_port #(
    parameter logic [21:0] TOUT_CYC = 22'(`TOUT_NS / `CLK_PERIOD_NS),
    parameter logic [21:0] READY_CYC = 22'(`READY_MAX_NS / `CLK_PERIOD_NS)
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic reset_n_i,
    input wire logic bus_sel_i,
    input wire logic addr_strap_0_i,
    input wire logic addr_strap_1_i,
    input wire logic addr_strap_2_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    output logic two_wire_en_o,
    output logic four_wire_en_o,
    output logic high_speed_mode_o,
    output logic comm_ready_o,
    output logic [15:0] analog_block_power_control_o,
    output logic [7:0] rd_addr_o,
    input wire logic [15:0] rd_data_i,
    output logic wr_valid_o,
    input wire logic wr_ready_i,
    output logic [7:0] wr_addr_o,
    output logic [15:0] wr_data_o
);

    localparam logic [21:0] SWRST_CYC = 22'(`SWRST_NS / `CLK_PERIOD_NS);
    i2c_port_pkg::port_state_t s;
    i2c_port_pkg::port_state_t next_s;

    logic scl_f;
    logic sda_f;
    logic rstn_f;
    logic hw;
    logic swr;
    logic push;
    logic pop;
    logic start;
    logic stop;
    logic scl_rise;
    logic scl_fall;
    logic blocked;
    logic [15:0] rd_word;
    logic [15:0] word;

    localparam logic [7:0][6:0] ADDR_TAB = {7'h2f, 7'h65, 7'h2d, 7'h62, 7'h2e, 7'h64, 7'h2c,
        7'h61};
    function automatic logic [6:0] slave_addr(input logic [2:0] strap);
        return ADDR_TAB[strap];
    endfunction

    function automatic i2c_port_pkg::port_state_t fresh(input logic [21:0] blk);
        i2c_port_pkg::port_state_t f;
        f = '0;
        f.st = i2c_port_pkg::st_idle;
        f.pwr = `PWR_RST;
        f.blk = blk;
        f.scl_q = 1'b1;
        f.sda_q = 1'b1;
        return f;
    endfunction

    pin_filter #(.FILT_CYC(`FILT_CYC), .RST_LEVEL(1'b1)) u_scl_filt (
        .clk_i(clk_i), .rst_i(rst_i), .pin_i(scl_i), .level_o(scl_f)
    );
    pin_filter #(.FILT_CYC(`FILT_CYC), .RST_LEVEL(1'b1)) u_sda_filt (
        .clk_i(clk_i), .rst_i(rst_i), .pin_i(sda_i), .level_o(sda_f)
    );
    pin_filter #(.FILT_CYC(`FILT_CYC), .RST_LEVEL(1'b0)) u_rst_filt (
        .clk_i(clk_i), .rst_i(rst_i), .pin_i(reset_n_i), .level_o(rstn_f)
    );

    assign hw = ~rstn_f;
    assign start = s.scl_q & scl_f & s.sda_q & ~sda_f;
    assign stop = s.scl_q & scl_f & ~s.sda_q & sda_f;
    assign scl_rise = ~s.scl_q & scl_f;
    assign scl_fall = s.scl_q & ~scl_f;
    assign blocked = (s.blk != 22'h0) | s.sel2;
    assign rd_word = (s.ptr == `PWR_PTR) ? s.pwr : rd_data_i;
    assign word = {s.hi, s.sh};
    assign pop = wr_valid_o & wr_ready_i;

    always_comb begin
        next_s = s;
        push = 1'b0;
        swr = 1'b0;
        next_s.strap1 = {addr_strap_0_i, addr_strap_1_i, addr_strap_2_i};
        next_s.strap2 = s.strap1;
        next_s.sel1 = bus_sel_i;
        next_s.sel2 = s.sel1;
        next_s.scl_q = scl_f;
        next_s.sda_q = sda_f;
        if (s.blk != 22'h0) begin
            next_s.blk = s.blk - 22'h1;
        end
        if (s.frame && (!scl_f || !sda_f)) begin
            next_s.tout = s.tout + 22'h1;
        end else begin
            next_s.tout = 22'h0;
        end
        if (start) begin
            next_s.st = i2c_port_pkg::st_addr;
            next_s.bitn = 4'h0;
            next_s.frame = 1'b1;
            next_s.drive = 1'b0;
        end else if (stop) begin
            next_s.st = i2c_port_pkg::st_idle;
            next_s.frame = 1'b0;
            next_s.hs = 1'b0;
            next_s.drive = 1'b0;
        end else if (s.tout >= TOUT_CYC) begin
            next_s.st = i2c_port_pkg::st_idle;
            next_s.frame = 1'b0;
            next_s.drive = 1'b0;
            next_s.tout = 22'h0;
        end else begin
            unique case (s.st)
                i2c_port_pkg::st_idle: begin
                end
                i2c_port_pkg::st_addr: begin
                    if (scl_rise) begin
                        next_s.sh = {s.sh[6:0], sda_f};
                        next_s.bitn = s.bitn + 4'h1;
                    end else if (scl_fall && s.bitn == `LAST_BIT) begin
                        if (s.sh[7:1] == slave_addr(s.strap2)) begin
                            next_s.st = i2c_port_pkg::st_addr_ack;
                            next_s.drive = 1'b1;
                            next_s.rw = s.sh[0];
                        end else begin
                            next_s.st = i2c_port_pkg::st_idle;
                            if (s.sh[7:3] == `HS_CODE) begin
                                next_s.hs = 1'b1;
                            end
                        end
                    end
                end
                i2c_port_pkg::st_addr_ack: begin
                    if (scl_fall) begin
                        next_s.bitn = 4'h0;
                        next_s.wr_ph = `PH_PTR;
                        if (s.rw) begin
                            next_s.st = i2c_port_pkg::st_rd_byte;
                            next_s.rsh = rd_word;
                            next_s.rd_lo = 1'b0;
                            next_s.drive = ~rd_word[15];
                        end else begin
                            next_s.st = i2c_port_pkg::st_wr_byte;
                            next_s.drive = 1'b0;
                        end
                    end
                end
                i2c_port_pkg::st_wr_byte: begin
                    if (scl_rise) begin
                        next_s.sh = {s.sh[6:0], sda_f};
                        next_s.bitn = s.bitn + 4'h1;
                    end else if (scl_fall && s.bitn == `LAST_BIT) begin
                        next_s.st = i2c_port_pkg::st_wr_ack;
                        next_s.drive = 1'b1;
                        unique case (s.wr_ph)
                            `PH_PTR: begin
                                next_s.ptr = s.sh;
                                next_s.wr_ph = `PH_HI;
                            end
                            `PH_HI: begin
                                next_s.hi = s.sh;
                                next_s.wr_ph = `PH_LO;
                            end
                            default: begin
                                next_s.wr_ph = `PH_PTR;
                                if (s.ptr == `SWRST_PTR) begin
                                    swr = ~s.sel2 | (word == `SWRST_KEY);
                                end else if (s.ptr == `PWR_PTR) begin
                                    next_s.pwr = word;
                                end else if (s.cnt == 2'h2) begin
                                    next_s.drive = 1'b0;
                                end else begin
                                    push = 1'b1;
                                end
                            end
                        endcase
                    end
                end
                i2c_port_pkg::st_wr_ack: begin
                    if (scl_fall) begin
                        next_s.st = i2c_port_pkg::st_wr_byte;
                        next_s.drive = 1'b0;
                        next_s.bitn = 4'h0;
                    end
                end
                i2c_port_pkg::st_rd_byte: begin
                    if (scl_fall) begin
                        next_s.rsh = {s.rsh[14:0], 1'b0};
                        if (s.bitn == 4'h7) begin
                            next_s.st = i2c_port_pkg::st_rd_ack;
                            next_s.drive = 1'b0;
                        end else begin
                            next_s.bitn = s.bitn + 4'h1;
                            next_s.drive = ~s.rsh[14];
                        end
                    end
                end
                i2c_port_pkg::st_rd_ack: begin
                    if (scl_rise) begin
                        next_s.mack = ~sda_f;
                    end else if (scl_fall) begin
                        next_s.bitn = 4'h0;
                        if (!s.mack) begin
                            next_s.st = i2c_port_pkg::st_idle;
                        end else if (!s.rd_lo) begin
                            next_s.st = i2c_port_pkg::st_rd_byte;
                            next_s.rd_lo = 1'b1;
                            next_s.drive = ~s.rsh[15];
                        end else begin
                            next_s.st = i2c_port_pkg::st_rd_byte;
                            next_s.rsh = rd_word;
                            next_s.rd_lo = 1'b0;
                            next_s.drive = ~rd_word[15];
                        end
                    end
                end
            endcase
        end
        if (blocked) begin
            next_s.st = i2c_port_pkg::st_idle;
            next_s.drive = 1'b0;
            next_s.frame = 1'b0;
            next_s.hs = 1'b0;
        end
        if (push) begin
            next_s.mem[s.wp] = {s.ptr, word};
            next_s.wp = ~s.wp;
        end
        if (pop) begin
            next_s.rp = ~s.rp;
        end
        next_s.cnt = s.cnt + {1'b0, push} - {1'b0, pop};
        if (hw) begin
            next_s = fresh(READY_CYC);
        end else if (swr) begin
            next_s = fresh(SWRST_CYC);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s <= fresh(READY_CYC);
        end else begin
            s <= next_s;
        end
    end

    assign sda_o = 1'b0;
    assign sda_oe_o = s.drive;
    assign two_wire_en_o = ~s.sel2;
    assign four_wire_en_o = s.sel2;
    assign high_speed_mode_o = s.hs;
    assign comm_ready_o = ~blocked;
    assign analog_block_power_control_o = s.pwr;
    assign rd_addr_o = s.ptr;
    assign wr_valid_o = s.cnt != 2'h0;
    assign wr_addr_o = s.mem[s.rp][23:16];
    assign wr_data_o = s.mem[s.rp][15:0];

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    property p_sel_exclusive;
        four_wire_en_o |-> !comm_ready_o ##1 !sda_oe_o;
    endproperty
    a_sel_exclusive: assert property (p_sel_exclusive) else $error("port selects clash");
    property p_addr_ack_match;
        s.st == i2c_port_pkg::st_addr_ack |-> s.sh[7:1] == slave_addr(s.strap2) && sda_oe_o;
    endproperty
    a_addr_ack_match: assert property (p_addr_ack_match) else $error("ack without match");
    property p_start_addr;
        start && !blocked && !hw && !stop |=> s.st == i2c_port_pkg::st_addr && s.bitn == 4'h0;
    endproperty
    a_start_addr: assert property (p_start_addr) else $error("start not taken");
    property p_stop_release;
        stop && !hw |=> s.st == i2c_port_pkg::st_idle && !sda_oe_o && !s.hs;
    endproperty
    a_stop_release: assert property (p_stop_release) else $error("stop not honoured");
    property p_hs_no_ack;
        s.st == i2c_port_pkg::st_addr && scl_fall && s.bitn == `LAST_BIT && !start && !stop
            && !blocked && !hw && s.sh[7:3] == `HS_CODE && s.tout < TOUT_CYC
            |=> high_speed_mode_o && !sda_oe_o;
    endproperty
    a_hs_no_ack: assert property (p_hs_no_ack) else $error("master code mishandled");
    property p_blocked_quiet;
        blocked |=> !sda_oe_o && s.st == i2c_port_pkg::st_idle;
    endproperty
    a_blocked_quiet: assert property (p_blocked_quiet) else $error("talks while blocked");
    property p_pin_reset;
        hw |=> analog_block_power_control_o == `PWR_RST && s.blk == READY_CYC && !sda_oe_o;
    endproperty
    a_pin_reset: assert property (p_pin_reset) else $error("pin reset missed");
    property p_ptr_hold;
        $changed(s.ptr) |-> $past(s.st == i2c_port_pkg::st_wr_byte && s.wr_ph == `PH_PTR) || $past(hw || swr);
    endproperty
    a_ptr_hold: assert property (p_ptr_hold) else $error("pointer moved");
    property p_timeout;
        s.tout >= TOUT_CYC && !hw |=> s.st == i2c_port_pkg::st_idle && !sda_oe_o && !s.frame;
    endproperty
    a_timeout: assert property (p_timeout) else $error("timeout ignored");
    property p_fifo_bound;
        push && !hw && s.cnt == 2'h0 |=> wr_addr_o == $past(s.ptr) && wr_data_o == $past(word);
    endproperty
    a_fifo_bound: assert property (p_fifo_bound) else $error("buffer head wrong");
    c_write_word: cover property (push);
    c_read_ack: cover property (s.st == i2c_port_pkg::st_rd_ack ##1 s.st == i2c_port_pkg::st_rd_byte);
    c_soft_reset: cover property (swr);
    c_high_speed_mode: cover property ($rose(high_speed_mode_o));
endmodule // i2c_slave_port

// [i2c_port_defs.svh]
`ifndef I2C_PORT_DEFS_SVH
`define I2C_PORT_DEFS_SVH

// clock and timing
`define CLK_PERIOD_NS 10
`define TOUT_NS 32800000
`define READY_MAX_NS 250000
`define SWRST_NS 30000

// glitch filter length in clocks
`define FILT_CYC 4'h3

// register pointers and values
`define PWR_PTR 8'h6b
`define PWR_RST 16'h0000
`define SWRST_PTR 8'h7c
`define SWRST_KEY 16'h6600

// address byte fields
`define HS_CODE 5'h01
`define LAST_BIT 4'h8

// write phase codes
`define PH_PTR 2'h0
`define PH_HI 2'h1
`define PH_LO 2'h2

`endif

// [i2c_port_pkg.sv]
package i2c_port_pkg;

    typedef enum logic [2:0] {
        st_idle,
        st_addr,
        st_addr_ack,
        st_wr_byte,
        st_wr_ack,
        st_rd_byte,
        st_rd_ack
    } st_t;

    typedef struct packed {
        logic s1;
        logic s2;
        logic [3:0] cnt;
        logic level;
    } filt_state_t;

    typedef struct packed {
        st_t st;
        logic [3:0] bitn;
        logic [7:0] sh;
        logic rw;
        logic [1:0] wr_ph;
        logic [7:0] ptr;
        logic [7:0] hi;
        logic [15:0] rsh;
        logic rd_lo;
        logic mack;
        logic drive;
        logic frame;
        logic hs;
        logic [15:0] pwr;
        logic [21:0] blk;
        logic [21:0] tout;
        logic [2:0] strap1;
        logic [2:0] strap2;
        logic sel1;
        logic sel2;
        logic [1:0][23:0] mem;
        logic wp;
        logic rp;
        logic [1:0] cnt;
        logic scl_q;
        logic sda_q;
    } port_state_t;

endpackage

// [pin_filter.sv]
`timescale 1ns/1ps
`include "i2c_port_defs.svh"

module pin_filter #(
    parameter logic [3:0] FILT_CYC = `FILT_CYC,
    parameter logic RST_LEVEL = 1'b1
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic pin_i,
    output logic level_o
);

    i2c_port_pkg::filt_state_t s;
    i2c_port_pkg::filt_state_t next_s;

    always_comb begin
        next_s = s;
        next_s.s1 = pin_i;
        next_s.s2 = s.s1;
        // level follows only after a stable run
        if (s.s2 == s.level) begin
            next_s.cnt = 4'h0;
        end else if (s.cnt >= FILT_CYC - 4'h1) begin
            next_s.level = s.s2;
            next_s.cnt = 4'h0;
        end else begin
            next_s.cnt = s.cnt + 4'h1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s <= '{s1: RST_LEVEL, s2: RST_LEVEL, cnt: 4'h0, level: RST_LEVEL};
        end else begin
            s <= next_s;
        end
    end

    assign level_o = s.level;

endmodule // pin_filter

// [i2c_master_model.sv]
`timescale 1ns/1ps

module i2c_master_model (
    input wire logic clk_i,
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_oe_o
);
    // bus idles released, clock high
    initial begin
        scl_o = 1'b1;
        sda_oe_o = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(negedge clk_i);
    endtask

    task automatic start();
        tick(4);
        sda_oe_o = 1'b0;
        tick(4);
        scl_o = 1'b1;
        tick(8);
        sda_oe_o = 1'b1;
        tick(8);
        scl_o = 1'b0;
    endtask

    task automatic xfer_bit(input logic b, output logic r);
        tick(4);
        sda_oe_o = ~b;
        tick(4);
        scl_o = 1'b1;
        tick(4);
        r = sda_i;
        tick(4);
        scl_o = 1'b0;
    endtask

    task automatic put(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            xfer_bit(d[i], r);
        end
        xfer_bit(1'b1, r);
        ack = ~r;
    endtask

    task automatic get(input logic ack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            xfer_bit(1'b1, r);
            d[i] = r;
        end
        xfer_bit(~ack, r);
    endtask

    task automatic stop();
        tick(4);
        sda_oe_o = 1'b1;
        tick(4);
        scl_o = 1'b1;
        tick(8);
        sda_oe_o = 1'b0;
        tick(8);
    endtask
endmodule // i2c_master_model

// [tb.sv]
`timescale 1ns/1ps

module tb;
    logic clk, rst, reset_n, bus_sel, wr_ready, sdo, oe, two_en, four_en, hs, ready, wr_valid;
    logic scl, m_oe, sda, a;
    logic [2:0] strap;
    logic [7:0] rd_addr, wr_addr, b;
    logic [15:0] rd_data, pwr, wr_data;
    logic [6:0] dev;
    logic [6:0] addr_tab [8] = '{7'h61, 7'h2c, 7'h64, 7'h2e, 7'h62, 7'h2d, 7'h65, 7'h2f};
    int err_total = 0;
    int comparisons = 0;

    // open-drain wire with pull-up
    assign sda = (oe ? sdo : 1'b1) & ~m_oe;
    assign dev = addr_tab[strap];

    i2c_slave_port #(.TOUT_CYC(22'd2000), .READY_CYC(22'd50)) i2c_slave_port_i (
        .clk_i(clk), .rst_i(rst), .reset_n_i(reset_n), .bus_sel_i(bus_sel),
        .addr_strap_0_i(strap[2]), .addr_strap_1_i(strap[1]), .addr_strap_2_i(strap[0]),
        .scl_i(scl), .sda_i(sda), .sda_o(sdo), .sda_oe_o(oe),
        .two_wire_en_o(two_en), .four_wire_en_o(four_en), .high_speed_mode_o(hs),
        .comm_ready_o(ready), .analog_block_power_control_o(pwr), .rd_addr_o(rd_addr),
        .rd_data_i(rd_data), .wr_valid_o(wr_valid), .wr_ready_i(wr_ready),
        .wr_addr_o(wr_addr), .wr_data_o(wr_data)
    );

    i2c_master_model i2c_master_model_i (
        .clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_oe_o(m_oe)
    );

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wait_ready();
        int n;
        n = 0;
        while (ready !== 1'b1 && n < 5000) begin
            @(negedge clk);
            n++;
        end
        check("comm_ready", 16'h1, {15'h0, ready});
    endtask

    task automatic addr_only(input logic [7:0] ab, input logic exp);
        i2c_master_model_i.start();
        i2c_master_model_i.put(ab, a);
        i2c_master_model_i.stop();
        check("addr_ack", {15'h0, exp}, {15'h0, a});
    endtask

    // pointer, high byte, low byte; returns low-byte ack
    task automatic word(input logic [7:0] p, input logic [15:0] d, output logic ack);
        i2c_master_model_i.put(p, ack);
        i2c_master_model_i.put(d[15:8], ack);
        i2c_master_model_i.put(d[7:0], ack);
    endtask

    task automatic wr_word(input logic [7:0] p, input logic [15:0] d, output logic ack);
        i2c_master_model_i.start();
        i2c_master_model_i.put({dev, 1'b0}, ack);
        word(p, d, ack);
        i2c_master_model_i.stop();
    endtask

    initial begin
        #400000;
        err_total++;
        stop_test();
    end

    initial begin
        rst = 1'b1;
        reset_n = 1'b1;
        bus_sel = 1'b0;
        strap = 3'h0;
        rd_data = 16'h0000;
        wr_ready = 1'b0;
        repeat (4) @(negedge clk);
        rst = 1'b0;
        wait_ready();
        check("pwr_default", 16'h0000, pwr);
        check("two_wire", 16'h1, {15'h0, two_en});
        check("four_wire", 16'h0, {15'h0, four_en});
        for (int s = 0; s < 8; s++) begin
            strap = 3'(s);
            repeat (10) @(negedge clk);
            addr_only({addr_tab[s], 1'b0}, 1'b1);
            addr_only({addr_tab[(s + 1) % 8], 1'b0}, 1'b0);
        end
        addr_only(8'h00, 1'b0);
        i2c_master_model_i.start();
        i2c_master_model_i.put({dev, 1'b0}, a);
        i2c_master_model_i.put(8'h6b, a);
        i2c_master_model_i.put(8'h12, a);
        check("pwr_after_hi", 16'h0000, pwr);
        i2c_master_model_i.put(8'h34, a);
        i2c_master_model_i.stop();
        check("pwr_after_lo", 16'h1234, pwr);
        // buffer fills while the user stalls
        i2c_master_model_i.start();
        i2c_master_model_i.put({dev, 1'b0}, a);
        for (int i = 0; i < 3; i++) begin
            word(8'h10 + 8'(i), 16'h0a01 + 16'(i), a);
            check("buf_ack", {15'h0, i < 2}, {15'h0, a});
        end
        i2c_master_model_i.stop();
        for (int i = 0; i < 2; i++) begin
            check("wr_valid", 16'h1, {15'h0, wr_valid});
            check("wr_addr", {8'h0, 8'h10 + 8'(i)}, {8'h0, wr_addr});
            check("wr_data", 16'h0a01 + 16'(i), wr_data);
            wr_ready = 1'b1;
            @(negedge clk);
            wr_ready = 1'b0;
        end
        check("wr_empty", 16'h0, {15'h0, wr_valid});
        rd_data = 16'ha55a;
        i2c_master_model_i.start();
        i2c_master_model_i.put({dev, 1'b0}, a);
        i2c_master_model_i.put(8'h20, a);
        i2c_master_model_i.start();
        i2c_master_model_i.put({dev, 1'b1}, a);
        check("rd_addr_ack", 16'h1, {15'h0, a});
        i2c_master_model_i.get(1'b1, b);
        check("rd_hi", 16'h00a5, {8'h0, b});
        rd_data = 16'h0ff0;
        i2c_master_model_i.get(1'b1, b);
        check("rd_lo_frozen", 16'h005a, {8'h0, b});
        i2c_master_model_i.get(1'b1, b);
        check("rd_hi_again", 16'h000f, {8'h0, b});
        i2c_master_model_i.get(1'b0, b);
        check("rd_lo_again", 16'h00f0, {8'h0, b});
        i2c_master_model_i.stop();
        check("pointer", 16'h0020, {8'h0, rd_addr});
        i2c_master_model_i.start();
        i2c_master_model_i.put(8'h09, a);
        check("hs_code_nack", 16'h0, {15'h0, a});
        check("hs_on", 16'h1, {15'h0, hs});
        i2c_master_model_i.start();
        i2c_master_model_i.put({dev, 1'b0}, a);
        check("hs_addr_ack", 16'h1, {15'h0, a});
        i2c_master_model_i.stop();
        check("hs_off", 16'h0, {15'h0, hs});
        wr_word(8'h7c, 16'h0001, a);
        check("swrst_pwr", 16'h0000, pwr);
        check("swrst_block", 16'h0, {15'h0, ready});
        addr_only({dev, 1'b0}, 1'b0);
        wait_ready();
        wr_word(8'h6b, 16'h00ff, a);
        check("pwr_set", 16'h00ff, pwr);
        reset_n = 1'b0;
        repeat (20) @(negedge clk);
        check("hwrst_pwr", 16'h0000, pwr);
        check("hwrst_block", 16'h0, {15'h0, ready});
        reset_n = 1'b1;
        wait_ready();
        bus_sel = 1'b1;
        repeat (10) @(negedge clk);
        check("four_sel", 16'h1, {15'h0, four_en});
        check("two_sel", 16'h0, {15'h0, two_en});
        addr_only({dev, 1'b0}, 1'b0);
        bus_sel = 1'b0;
        wait_ready();
        i2c_master_model_i.start();
        i2c_master_model_i.put({dev, 1'b1}, a);
        i2c_master_model_i.tick(10);
        check("tout_hold", 16'h1, {15'h0, oe});
        i2c_master_model_i.tick(2100);
        check("tout_release", 16'h0, {15'h0, oe});
        i2c_master_model_i.put(8'h6b, a);
        check("tout_idle", 16'h0, {15'h0, a});
        i2c_master_model_i.stop();
        addr_only({dev, 1'b0}, 1'b1);
        check("drive_low_only", 16'h0, {15'h0, sdo});
        stop_test();
    end
endmodule // tb
